// File: hdl/hftc_pkg.sv
// constants and types for the hypervisor feature trap control block
package hftc_pkg;
    localparam int ACR_TRAP_BIT    = 31;
    localparam int AMON_TRAP_BIT   = 30;
    localparam int TRACE_TRAP_BIT  = 20;
    localparam int MATRIX_TRAP_BIT = 12;
    localparam int FP_TRAP_BIT     = 10;
    localparam int VEC_TRAP_BIT    = 8;
    localparam logic [63:0] WR_MASK   = 64'h0000_0000_C010_1500;
    localparam logic [63:0] RES1_MASK = 64'h0000_0000_0000_22FF;
    localparam logic [5:0] EC_SYSREG = 6'h18;
    localparam logic [5:0] EC_CP_ONE = 6'h03;
    localparam logic [5:0] EC_CP_TWO = 6'h04;
    localparam logic [5:0] EC_CP14   = 6'h05;
    localparam logic [5:0] EC_FP     = 6'h07;
    localparam logic [5:0] EC_VEC    = 6'h19;
    localparam logic [5:0] EC_MATRIX = 6'h1D;
    localparam logic [24:0] ISS_ZERO = 25'h0000000;
    localparam logic [1:0] TRC_OP0   = 2'h2;
    localparam logic [2:0] TRC_OP1   = 3'h1;
    localparam logic [3:0] TRC_CRN   = 4'h8;
    localparam logic [3:0] TRC_CPNUM = 4'hE;
    localparam logic [2:0] TRC_OPC1  = 3'h1;
    localparam logic [2:0] NV_ALL    = 3'h7;
    localparam logic [11:0] NV_OFS   = 12'h100;
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;

    typedef enum logic [3:0] {
        ACC_OTHER  = 4'b0000, ACC_AMU64  = 4'b0001, ACC_AMU32  = 4'b0010,
        ACC_AMUDW  = 4'b0011, ACC_SYS64  = 4'b0100, ACC_CP14   = 4'b0101,
        ACC_FP     = 4'b0110, ACC_MATRIX = 4'b0111, ACC_STREAMING_VECTOR_CONTROL   = 4'b1000,
        ACC_VECTOR = 4'b1001, ACC_ZCR    = 4'b1010, ACC_OWN_RD = 4'b1011,
        ACC_OWN_WR = 4'b1100, ACC_ACR_RD = 4'b1101, ACC_ACR_WR = 4'b1110
    } hftc_kind_t;

    typedef enum logic [2:0] {
        ACT_PROCEED = 3'b000, ACT_UNDEF = 3'b001, ACT_TRAP2 = 3'b010,
        ACT_TRAP3   = 3'b011, ACT_NESTED_VIRT_MEMORY_PAGE = 3'b100
    } hftc_act_t;

    typedef struct packed {
        logic        valid;
        hftc_kind_t  kind;
        logic [1:0]  el;
        logic [1:0]  op0;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  cpnum;
        logic [2:0]  opc1;
        logic [63:0] wdata;
    } hftc_req_t;

    typedef struct packed {
        logic       el2Enabled;
        logic       el3Present;
        logic [2:0] nvBits;
        logic       hostExtEnable;
        logic       halted;
        logic       secureDebugDisable;
        logic       monitorAcrTrap;
        logic       fineGrainTrapEnable;
        logic       fineGrainReadTrap;
        logic       fineGrainWriteTrap;
        logic       streamingMode;
        logic       hasVector;
        logic       hasMatrix;
    } hftc_ctx_t;

    typedef struct packed {
        logic        valid;
        hftc_act_t   action;
        logic [5:0]  ec;
        logic [24:0] iss;
        logic        commit;
        logic [63:0] rdata;
        logic [11:0] memOffset;
    } hftc_resp_t;
endpackage

// File: hdl/hftc_trap_ctrl.sv
// hypervisor feature trap decision logic with its trap register
//
// Function
// - activity-monitor bit 30 diverts level 1/0 monitor accesses upward
// - trapped 64-bit monitor register accesses report class 0x18
// - single-word coprocessor monitor moves report class 0x03
// - double-word coprocessor counter moves report class 0x04
// - trace bit 20 traps op0=2, op1=1, CRn<8 accesses, class 0x18
// - trace bit traps coprocessor 14, opc1=1, CRn<8 accesses, class 0x05
// - level 0 trace accesses are undefined, ahead of the trace trap
// - a trapped trace access performs no side effect
// - matrix bit 12 traps matrix work and control registers, levels 2-0
// - matrix trap also catches streaming/no-feature vector ops, set ops
// - matrix trap reports class 0x1D with all-zero syndrome detail
// - matrix bit never alters register content validity
// - matrix trap wins over the floating-point trap
// - floating-point bit 10 traps SIMD/FP accesses with class 0x07
// - floating-point trap also diverts matrix and vector ops, 0x07
// - vector bit 8 traps non-streaming vector ops and length regs, 0x19
// - vector trap wins over the floating-point trap
// - vector and matrix fields read one when the feature is absent
// - trap fields hold no defined value after warm reset
// - level 0 own access undefined; level 1 traps if nested, else undef
// - level 2 with monitor trap: undefined if halted+sdd, else level 3
// - level 1 access-control read traps on bit 31 or fine-grain trap
// - nested controls 111 redirect level 1 access-control register access to memory at 0x100
// - level 2 host-extension access-control read returns trap register
`timescale 1ns/1ps
module hftc_trap_ctrl (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire hftc_pkg::hftc_req_t  req,
    input  wire hftc_pkg::hftc_ctx_t  ctx,
    output hftc_pkg::hftc_resp_t      resp
);
    import hftc_pkg::*;

    logic [63:0] trapRegQ;
    logic [63:0] acrRegQ;
    hftc_resp_t  respQ;
    hftc_resp_t  respD;
    logic        lowEl;
    logic        featEl;
    logic        mTrap;
    logic        vTrap;
    logic        fTrap;
    logic        monUndef;
    logic        trapWrite;
    logic        acrWrite;

    // readback view; absent features show their field as one
    function automatic logic [63:0] trapView(input logic [63:0] q,
                                             input hftc_ctx_t c);
        logic [63:0] v;
        v = (q & WR_MASK) | RES1_MASK;
        v[VEC_TRAP_BIT] = q[VEC_TRAP_BIT] | ~c.hasVector;
        v[MATRIX_TRAP_BIT] = q[MATRIX_TRAP_BIT] | ~c.hasMatrix;
        return v;
    endfunction

    function automatic logic isTrace(input hftc_req_t r);
        if (r.kind == ACC_CP14)
            return r.cpnum == TRC_CPNUM && r.opc1 == TRC_OPC1
                   && r.crn < TRC_CRN;
        return r.kind == ACC_SYS64 && r.op0 == TRC_OP0
               && r.op1 == TRC_OP1 && r.crn < TRC_CRN;
    endfunction

    assign lowEl  = ctx.el2Enabled && !req.el[1];
    assign featEl = ctx.el2Enabled && req.el != EL3;
    // matrix trap is independent of register validity; no state touched
    assign mTrap  = featEl && trapRegQ[MATRIX_TRAP_BIT]
                    && ctx.hasMatrix;
    assign vTrap  = featEl && trapRegQ[VEC_TRAP_BIT] && ctx.hasVector;
    assign fTrap  = featEl && trapRegQ[FP_TRAP_BIT];
    assign monUndef = ctx.halted && ctx.secureDebugDisable;

    always_comb begin
        respD = '0;
        respD.valid = req.valid;
        respD.action = ACT_PROCEED;
        respD.iss = ISS_ZERO;
        unique case (req.kind)
            ACC_AMU64, ACC_AMU32, ACC_AMUDW: begin
                if (lowEl && trapRegQ[AMON_TRAP_BIT]) begin
                    respD.action = ACT_TRAP2;
                    if (req.kind == ACC_AMU64)
                        respD.ec = EC_SYSREG;
                    else if (req.kind == ACC_AMU32)
                        respD.ec = EC_CP_ONE;
                    else
                        respD.ec = EC_CP_TWO;
                end
            end
            ACC_SYS64, ACC_CP14: begin
                if (isTrace(req) && req.el == EL0) begin
                    respD.action = ACT_UNDEF;
                end else if (isTrace(req) && lowEl
                             && trapRegQ[TRACE_TRAP_BIT]) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = (req.kind == ACC_CP14)
                               ? EC_CP14 : EC_SYSREG;
                end
            end
            ACC_FP: begin
                if (fTrap) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_FP;
                end
            end
            ACC_MATRIX, ACC_STREAMING_VECTOR_CONTROL: begin
                if (mTrap) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_MATRIX;
                end else if (fTrap && req.kind == ACC_MATRIX) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_FP;
                end
            end
            ACC_VECTOR: begin
                if (ctx.streamingMode || !ctx.hasVector) begin
                    if (mTrap) begin
                        respD.action = ACT_TRAP2;
                        respD.ec = EC_MATRIX;
                    end else if (fTrap) begin
                        respD.action = ACT_TRAP2;
                        respD.ec = EC_FP;
                    end
                end else if (vTrap) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_VEC;
                end else if (fTrap) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_FP;
                end
            end
            ACC_ZCR: begin
                if (vTrap) begin
                    respD.action = ACT_TRAP2;
                    respD.ec = EC_VEC;
                end
            end
            ACC_OWN_RD, ACC_OWN_WR: begin
                unique case (req.el)
                    EL0: respD.action = ACT_UNDEF;
                    EL1: begin
                        respD.action = (ctx.el2Enabled && ctx.nvBits[0])
                                       ? ACT_TRAP2 : ACT_UNDEF;
                        respD.ec = ctx.el2Enabled && ctx.nvBits[0]
                                   ? EC_SYSREG : 6'h00;
                    end
                    EL2: begin
                        if (ctx.el3Present && ctx.monitorAcrTrap) begin
                            respD.action = monUndef ? ACT_UNDEF
                                                    : ACT_TRAP3;
                            respD.ec = monUndef ? 6'h00 : EC_SYSREG;
                        end
                    end
                    EL3: respD.action = ACT_PROCEED;
                endcase
                if (respD.action == ACT_PROCEED && req.kind == ACC_OWN_RD)
                    respD.rdata = trapView(trapRegQ, ctx);
            end
            ACC_ACR_RD, ACC_ACR_WR: begin
                unique case (req.el)
                    EL0: respD.action = ACT_UNDEF;
                    EL1: begin
                        if (ctx.el3Present && ctx.monitorAcrTrap
                            && monUndef) begin
                            respD.action = ACT_UNDEF;
                        end else if (ctx.el2Enabled
                            && trapRegQ[ACR_TRAP_BIT]) begin
                            respD.action = ACT_TRAP2;
                            respD.ec = EC_SYSREG;
                        end else if (ctx.el2Enabled && (!ctx.el3Present
                            || ctx.fineGrainTrapEnable)
                            && (req.kind == ACC_ACR_RD
                                ? ctx.fineGrainReadTrap
                                : ctx.fineGrainWriteTrap)) begin
                            respD.action = ACT_TRAP2;
                            respD.ec = EC_SYSREG;
                        end else if (ctx.el3Present && ctx.monitorAcrTrap)
                        begin
                            respD.action = ACT_TRAP3;
                            respD.ec = EC_SYSREG;
                        end else if (ctx.el2Enabled
                                     && ctx.nvBits == NV_ALL) begin
                            respD.action = ACT_NESTED_VIRT_MEMORY_PAGE;
                            respD.memOffset = NV_OFS;
                        end
                    end
                    EL2: begin
                        if (ctx.el3Present && ctx.monitorAcrTrap) begin
                            respD.action = monUndef ? ACT_UNDEF
                                                    : ACT_TRAP3;
                            respD.ec = monUndef ? 6'h00 : EC_SYSREG;
                        end
                    end
                    EL3: respD.action = ACT_PROCEED;
                endcase
                if (respD.action == ACT_PROCEED && req.kind == ACC_ACR_RD)
                    respD.rdata = (req.el == EL2 && ctx.hostExtEnable)
                                  ? trapView(trapRegQ, ctx)
                                  : acrRegQ;
            end
            default: respD.action = ACT_PROCEED;
        endcase
        // side effects only for an access that really proceeds
        respD.commit = req.valid
                       && respD.action == ACT_PROCEED;
        if (!req.valid)
            respD = '0;
    end

    assign trapWrite = respD.commit && (req.kind == ACC_OWN_WR
                       || (req.kind == ACC_ACR_WR && req.el == EL2
                           && ctx.hostExtEnable));
    assign acrWrite  = respD.commit && req.kind == ACC_ACR_WR
                       && !(req.el == EL2 && ctx.hostExtEnable);

    // deliberately not reset: fields are unknown after warm reset
    always_ff @(posedge core_clk) begin
        if (trapWrite)
            trapRegQ <= req.wdata & WR_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            acrRegQ <= 64'h0000_0000_0000_0000;
        else if (acrWrite)
            acrRegQ <= req.wdata;
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            respQ <= '0;
        else
            respQ <= respD;
    end

    assign resp = respQ;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_amu64;
        req.valid && req.kind == ACC_AMU64 && lowEl
        && trapRegQ[AMON_TRAP_BIT];
    endsequence
    sequence s_trapTo(logic [5:0] e);
        resp.valid && resp.action == ACT_TRAP2 && resp.ec == e
        && !resp.commit;
    endsequence

    property p_amu64;
        s_amu64 |=> s_trapTo(EC_SYSREG);
    endproperty
    a_amu64: assert property (p_amu64)
        else $error("monitor 64-bit access not trapped with 0x18");

    property p_amuDw;
        req.valid && req.kind == ACC_AMUDW && lowEl
        && trapRegQ[AMON_TRAP_BIT] |=> s_trapTo(EC_CP_TWO);
    endproperty
    a_amuDw: assert property (p_amuDw)
        else $error("monitor double move not trapped with 0x04");

    property p_traceEl0;
        req.valid && isTrace(req) && req.el == EL0
        |=> resp.action == ACT_UNDEF && !resp.commit;
    endproperty
    a_traceEl0: assert property (p_traceEl0)
        else $error("level 0 trace access not undefined");

    property p_cp14;
        req.valid && req.kind == ACC_CP14 && isTrace(req)
        && req.el == EL1 && ctx.el2Enabled && trapRegQ[TRACE_TRAP_BIT]
        |=> s_trapTo(EC_CP14);
    endproperty
    a_cp14: assert property (p_cp14)
        else $error("coprocessor 14 trace access not trapped with 0x05");

    property p_matrix;
        req.valid && req.kind == ACC_MATRIX && mTrap
        |=> s_trapTo(EC_MATRIX) && resp.iss == ISS_ZERO;
    endproperty
    a_matrix: assert property (p_matrix)
        else $error("matrix trap missing or wrong syndrome");

    property p_vecPrio;
        req.valid && req.kind == ACC_VECTOR && !ctx.streamingMode
        && vTrap && fTrap |=> s_trapTo(EC_VEC);
    endproperty
    a_vecPrio: assert property (p_vecPrio)
        else $error("vector trap lost to floating-point trap");

    property p_ownEl0;
        req.valid && req.kind inside {ACC_OWN_RD, ACC_OWN_WR}
        && req.el == EL0 |=> resp.action == ACT_UNDEF;
    endproperty
    a_ownEl0: assert property (p_ownEl0)
        else $error("level 0 trap register access not undefined");

    property p_nested_virt_memory_page;
        resp.valid && resp.action == ACT_NESTED_VIRT_MEMORY_PAGE
        |-> resp.memOffset == NV_OFS && $past(ctx.nvBits) == NV_ALL
            && $past(req.el) == EL1;
    endproperty
    a_nested_virt_memory_page: assert property (p_nested_virt_memory_page)
        else $error("nested redirect without 111 or wrong offset");

    property p_resBits;
        req.valid && req.kind == ACC_OWN_RD && req.el == EL3
        |=> (resp.rdata & RES1_MASK) == RES1_MASK
            && (resp.rdata & ~(WR_MASK | RES1_MASK)) == 64'h0;
    endproperty
    a_resBits: assert property (p_resBits)
        else $error("reserved trap register bits read wrongly");

    property p_noCommit;
        resp.valid && resp.action != ACT_PROCEED |-> !resp.commit;
    endproperty
    a_noCommit: assert property (p_noCommit)
        else $error("trapped access allowed to commit");
endmodule // hftc_trap_ctrl

// File: dv/hftc_exc_entry_model.sv
// exception entry side model: latches each answer and tallies exceptions
`timescale 1ns/1ps
module hftc_exc_entry_model (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire hftc_pkg::hftc_resp_t resp,
    output hftc_pkg::hftc_resp_t      lastResp,
    output logic [15:0]               excCount
);
    // answers stand one cycle; latched every edge so a missing one shows
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lastResp <= '0;
        end else begin
            lastResp <= resp;
        end
    end
    // a proceed answer enters no exception
    always_ff @(posedge core_clk) begin
        if (rst) begin
            excCount <= 16'h0000;
        end else if (resp.valid && resp.action != hftc_pkg::ACT_PROCEED) begin
            excCount <= excCount + 16'h0001;
        end
    end
endmodule // hftc_exc_entry_model

// File: dv/hftc_tb.sv
// self-checking bench for the hypervisor feature trap block
`timescale 1ns/1ps
module tb;
    localparam hftc_pkg::hftc_act_t PRC = hftc_pkg::ACT_PROCEED;
    localparam hftc_pkg::hftc_act_t UND = hftc_pkg::ACT_UNDEF;
    localparam hftc_pkg::hftc_act_t TR2 = hftc_pkg::ACT_TRAP2;
    localparam hftc_pkg::hftc_act_t TR3 = hftc_pkg::ACT_TRAP3;
    localparam hftc_pkg::hftc_act_t NVM = hftc_pkg::ACT_NESTED_VIRT_MEMORY_PAGE;
    logic                 core_clk;
    logic                 rst;
    hftc_pkg::hftc_req_t  rq;
    hftc_pkg::hftc_ctx_t  cx;
    hftc_pkg::hftc_resp_t resp;
    hftc_pkg::hftc_resp_t lastResp;
    logic [15:0]          excCount;
    logic [15:0]          expExc;
    logic [3:0]           crnSel;
    int                   errors;
    int                   checkCount;

    hftc_trap_ctrl dut_u (
        .core_clk (core_clk),
        .rst      (rst),
        .req      (rq),
        .ctx      (cx),
        .resp     (resp)
    );
    hftc_exc_entry_model exc_u (
        .core_clk (core_clk),
        .rst      (rst),
        .resp     (resp),
        .lastResp (lastResp),
        .excCount (excCount)
    );

    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // default context: both upper levels present, both features present
    task automatic base();
        cx = '0;
        cx.el2Enabled = 1'h1;
        cx.el3Present = 1'h1;
        cx.hasVector  = 1'h1;
        cx.hasMatrix  = 1'h1;
    endtask

    // one access: presented for one edge, answer judged the cycle after
    task automatic acc(input hftc_pkg::hftc_kind_t k, input logic [1:0] el,
                       input logic [63:0] wd, input hftc_pkg::hftc_act_t ea,
                       input logic [5:0] eec);
        rq       = '0;
        rq.valid = 1'h1;
        rq.kind  = k;
        rq.el    = el;
        rq.op0   = 2'h2;
        rq.op1   = 3'h1;
        rq.crn   = crnSel;
        rq.cpnum = 4'hE;
        rq.opc1  = 3'h1;
        rq.wdata = wd;
        @(posedge core_clk);
        #1 rq.valid = 1'h0;
        @(posedge core_clk);
        #1;
        chk(lastResp.valid, 64'h1, "answer present");
        chk(lastResp.action, ea, "action");
        chk(lastResp.ec, (ea == TR2 || ea == TR3) ? eec : 6'h00, "class");
        chk(lastResp.iss, 64'h0, "syndrome detail");
        chk(lastResp.commit, ea == PRC, "commit");
        chk(lastResp.memOffset, (ea == NVM) ? 12'h100 : 12'h000, "offset");
        if (ea != PRC) begin
            expExc = expExc + 16'h0001;
        end
    endtask

    task automatic wr(input logic [63:0] v);
        acc(hftc_pkg::ACC_OWN_WR, 2'h3, v, PRC, 6'h00);
    endtask

    task automatic rd(input hftc_pkg::hftc_kind_t k, input logic [1:0] el,
                      input logic [63:0] exp);
        acc(k, el, 64'h0, PRC, 6'h00);
        chk(lastResp.rdata, exp, "read data");
    endtask

    initial begin
        #200000;
        errors++;
        $display("[FAIL] %0t: run did not complete", $time);
        finish_test();
    end

    initial begin
        rq = '0;
        base();
        crnSel = 4'h0;
        expExc = 16'h0000;
        errors = 0;
        checkCount = 0;
        rst = 1'h1;
        repeat (6) @(posedge core_clk);
        #1 chk(resp.valid, 64'h0, "quiet in reset");
        rst = 1'h0;
        // register layout: fixed ones and zeros, writable trap bits only
        wr(64'hFFFF_FFFF_FFFF_FFFF);
        rd(hftc_pkg::ACC_OWN_RD, 2'h3, 64'hC010_37FF);
        wr(64'h0);
        rd(hftc_pkg::ACC_OWN_RD, 2'h3, 64'h22FF);
        cx.hasVector = 1'h0;
        cx.hasMatrix = 1'h0;
        rd(hftc_pkg::ACC_OWN_RD, 2'h3, 64'h33FF);
        base();
        $display("test register layout done");
        // every trap bit set, bit 31 included
        wr(64'hC010_1500);
        acc(hftc_pkg::ACC_AMU64, 2'h1, 64'h0, TR2, 6'h18);
        acc(hftc_pkg::ACC_AMU32, 2'h0, 64'h0, TR2, 6'h03);
        acc(hftc_pkg::ACC_AMUDW, 2'h1, 64'h0, TR2, 6'h04);
        acc(hftc_pkg::ACC_AMU64, 2'h2, 64'h0, PRC, 6'h00);
        crnSel = 4'h7;
        acc(hftc_pkg::ACC_SYS64, 2'h1, 64'h0, TR2, 6'h18);
        acc(hftc_pkg::ACC_CP14, 2'h1, 64'h0, TR2, 6'h05);
        acc(hftc_pkg::ACC_SYS64, 2'h0, 64'h0, UND, 6'h00);
        crnSel = 4'h8;
        acc(hftc_pkg::ACC_SYS64, 2'h1, 64'h0, PRC, 6'h00);
        crnSel = 4'h0;
        acc(hftc_pkg::ACC_MATRIX, 2'h2, 64'h0, TR2, 6'h1D);
        acc(hftc_pkg::ACC_STREAMING_VECTOR_CONTROL, 2'h1, 64'h0, TR2, 6'h1D);
        cx.streamingMode = 1'h1;
        acc(hftc_pkg::ACC_VECTOR, 2'h0, 64'h0, TR2, 6'h1D);
        cx.streamingMode = 1'h0;
        acc(hftc_pkg::ACC_VECTOR, 2'h1, 64'h0, TR2, 6'h19);
        acc(hftc_pkg::ACC_ZCR, 2'h2, 64'h0, TR2, 6'h19);
        acc(hftc_pkg::ACC_FP, 2'h0, 64'h0, TR2, 6'h07);
        cx.el2Enabled = 1'h0;
        acc(hftc_pkg::ACC_FP, 2'h1, 64'h0, PRC, 6'h00);
        base();
        $display("test all traps done");
        // floating-point bit alone, then matrix bit alone
        wr(64'h400);
        acc(hftc_pkg::ACC_MATRIX, 2'h1, 64'h0, TR2, 6'h07);
        acc(hftc_pkg::ACC_VECTOR, 2'h1, 64'h0, TR2, 6'h07);
        wr(64'h1000);
        cx.hasVector = 1'h0;
        acc(hftc_pkg::ACC_VECTOR, 2'h1, 64'h0, TR2, 6'h1D);
        base();
        wr(64'h0);
        acc(hftc_pkg::ACC_AMU64, 2'h1, 64'h0, PRC, 6'h00);
        $display("test single traps done");
        // access to the trap register itself from each level
        acc(hftc_pkg::ACC_OWN_RD, 2'h0, 64'h0, UND, 6'h00);
        acc(hftc_pkg::ACC_OWN_WR, 2'h1, 64'h400, UND, 6'h00);
        cx.nvBits = 3'h1;
        acc(hftc_pkg::ACC_OWN_WR, 2'h1, 64'h400, TR2, 6'h18);
        base();
        rd(hftc_pkg::ACC_OWN_RD, 2'h3, 64'h22FF);
        cx.monitorAcrTrap = 1'h1;
        acc(hftc_pkg::ACC_OWN_RD, 2'h2, 64'h0, TR3, 6'h18);
        cx.halted = 1'h1;
        cx.secureDebugDisable = 1'h1;
        acc(hftc_pkg::ACC_OWN_WR, 2'h2, 64'h400, UND, 6'h00);
        base();
        wr(64'h400);
        rd(hftc_pkg::ACC_OWN_RD, 2'h2, 64'h26FF);
        $display("test own access done");
        // access control register paths
        wr(64'h8000_0000);
        acc(hftc_pkg::ACC_ACR_RD, 2'h0, 64'h0, UND, 6'h00);
        acc(hftc_pkg::ACC_ACR_RD, 2'h1, 64'h0, TR2, 6'h18);
        wr(64'h0);
        cx.fineGrainTrapEnable = 1'h1;
        cx.fineGrainReadTrap = 1'h1;
        acc(hftc_pkg::ACC_ACR_RD, 2'h1, 64'h0, TR2, 6'h18);
        base();
        cx.nvBits = 3'h7;
        acc(hftc_pkg::ACC_ACR_RD, 2'h1, 64'h0, NVM, 6'h00);
        base();
        acc(hftc_pkg::ACC_ACR_WR, 2'h3, 64'h0030_0000, PRC, 6'h00);
        rd(hftc_pkg::ACC_ACR_RD, 2'h1, 64'h0030_0000);
        cx.fineGrainTrapEnable = 1'h1;
        cx.fineGrainWriteTrap = 1'h1;
        acc(hftc_pkg::ACC_ACR_WR, 2'h1, 64'h0, TR2, 6'h18);
        rd(hftc_pkg::ACC_ACR_RD, 2'h3, 64'h0030_0000);
        base();
        cx.monitorAcrTrap = 1'h1;
        acc(hftc_pkg::ACC_ACR_RD, 2'h1, 64'h0, TR3, 6'h18);
        base();
        wr(64'h100);
        cx.hostExtEnable = 1'h1;
        rd(hftc_pkg::ACC_ACR_RD, 2'h2, 64'h23FF);
        acc(hftc_pkg::ACC_ACR_WR, 2'h2, 64'h1000, PRC, 6'h00);
        rd(hftc_pkg::ACC_OWN_RD, 2'h3, 64'h32FF);
        base();
        chk(excCount, expExc, "exceptions entered");
        $display("test access control done");
        finish_test();
    end
endmodule // tb
